/* verilog/acp_pkg.sv */
// shared constants and carrier types for the coprocessor host port
package acp_pkg;
   localparam int unsigned DATA_W       = 8;
   localparam int unsigned STACK_DEPTH  = 16;
   localparam int unsigned SP_W         = 4;
   localparam int unsigned FIFO_DEPTH   = 16;
   localparam int unsigned EXEC_CYCLES  = 8;
   localparam logic [3:0]  EXEC_CNT_W1  = 4'h7;
   localparam logic [3:0]  CNT_ZERO     = 4'h0;
   localparam logic [SP_W-1:0] SP_RESET = 4'h0;
   localparam logic [SP_W-1:0] SP_ONE   = 4'h1;
   localparam int unsigned CMD_SVC_BIT  = 7;
   localparam int unsigned CMD_OP_LSB   = 0;
   localparam logic [6:0]  OP_NOP       = 7'h00;
   localparam logic [6:0]  OP_ADD       = 7'h01;
   localparam logic [6:0]  OP_SUB       = 7'h02;
   localparam logic [6:0]  OP_XCH       = 7'h03;
   localparam int unsigned ST_BUSY_BIT  = 7;
   localparam int unsigned ST_EMPTY_BIT = 6;
   localparam int unsigned ST_ERR_BIT   = 0;
   localparam logic [7:0]  STATUS_RESET = 8'h00;
   localparam logic [7:0]  CMD_INIT     = 8'h00;

   typedef enum logic [1:0] {
      ACP_IDLE = 2'b00,
      ACP_EXEC = 2'b01,
      ACP_DONE = 2'b11
   } acp_state_t;

   // one decoded bus access: kind bits plus data byte
   typedef struct packed {
      logic       cmd_sel;
      logic       is_write;
      logic [7:0] data;
   } acp_xfer_t;
endpackage

/* verilog/acp_fifo.sv */
// parameterised valid/ready fifo in flip-flops
`timescale 1ns/1ns
`default_nettype none
module acp_fifo #(
   parameter int unsigned WIDTH = 10,
   parameter int unsigned DEPTH = 16
) (
   input  wire logic             mclk,
   input  wire logic             rst_b,
   input  wire logic             in_valid,
   output logic                  in_ready,
   input  wire logic [WIDTH-1:0] in_data,
   output logic                  out_valid,
   input  wire logic             out_ready,
   output logic [WIDTH-1:0]      out_data
);
   localparam int unsigned AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem_q [DEPTH];
   logic [AW-1:0]    wr_q;
   logic [AW-1:0]    rd_q;
   logic [AW:0]      cnt_q;
   wire              push;
   wire              pop;

   assign push      = in_valid && in_ready;
   assign pop       = out_valid && out_ready;
   assign in_ready  = (cnt_q != (AW+1)'(DEPTH));
   assign out_valid = (cnt_q != '0);
   assign out_data  = mem_q[rd_q];

   always_ff @(posedge mclk) begin
      if (!rst_b) begin
         wr_q  <= '0;
         rd_q  <= '0;
         cnt_q <= '0;
      end else begin
         if (push) wr_q <= wr_q + 1'b1;
         if (pop) rd_q <= rd_q + 1'b1;
         cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
      end
   end

   generate
      for (genvar i = 0; i < DEPTH; i++) begin : g_ent
         always_ff @(posedge mclk) begin
            if (push && wr_q == AW'(i)) mem_q[i] <= in_data;
         end
      end
   endgenerate
endmodule
`default_nettype wire

/* verilog/acp_host_port.sv */
// host byte port of the stack arithmetic coprocessor
// How it works
// - all transfers use one 8-bit data bus
// - operands on stack; results stay there
// - completion indication raised after each command
// - strobes may be asynchronous to mclk
// - reset initialises and aborts running command
// - reset clears every status bit
// - reset clears stack pointer, keeps command
// - after reset done_n high (completion inactive) and service low
// - decode from select plus strobe kind
// - select low: write pushes, read pops
// - select high: write command, read status
// - completion cleared by ack, access, reset
// - service request gated by command bit
// - push lsb first, pop msb first
`timescale 1ns/1ns
`default_nettype none
module acp_host_port (
   input  wire logic       mclk,
   input  wire logic       rst_b,
   input  wire logic       cmd_sel,
   input  wire logic       rd_n,
   input  wire logic       wr_n,
   input  wire logic [7:0] db_in,
   output logic [7:0]      db_out,
   output logic            db_oe,
   output logic            done_n,
   input  wire logic       done_ack_n,
   output logic            service_request,
   input  wire logic       service_ack_n
);
   ////////////////////////////////////////////////////////////////
   // strobe synchronisers and edge detect
   logic [1:0] rd_meta_q;
   logic [1:0] wr_meta_q;
   logic       rd_s_q;
   logic       wr_s_q;
   logic       rd_act_q;
   logic       wr_act_q;
   logic       cs_q;
   logic [7:0] wd_q;

   always_ff @(posedge mclk) begin
      rd_meta_q <= {rd_meta_q[0], ~rd_n};
      wr_meta_q <= {wr_meta_q[0], ~wr_n};
      rd_s_q    <= rd_meta_q[1];
      wr_s_q    <= wr_meta_q[1];
      cs_q      <= cmd_sel;
      wd_q      <= db_in;
   end

   // write acts on trailing edge so data is settled; read on leading
   wire rd_start = rd_meta_q[1] && !rd_s_q;
   wire wr_end   = !wr_meta_q[1] && wr_s_q;
   wire rd_any   = rd_meta_q[1];
   // overlap is undefined, so a read starting while a write strobe is low is dropped
   wire both     = rd_meta_q[1] && wr_meta_q[1];

   ////////////////////////////////////////////////////////////////
   // access fifo: decoupled from the stack engine
   acp_pkg::acp_xfer_t in_x;
   acp_pkg::acp_xfer_t out_x;
   logic               f_in_ready;
   logic               f_out_valid;
   wire                f_in_valid;
   wire                f_out_ready;

   assign in_x.cmd_sel  = cs_q;
   assign in_x.is_write = wr_end;
   assign in_x.data     = wd_q;
   // reads of status are answered directly and bypass the fifo
   assign f_in_valid = !both && (wr_end || (rd_start && !cs_q));
   // a full queue drops the access; software sees it as an error
   wire lost = f_in_valid && !f_in_ready;

   acp_fifo #(
      .WIDTH ($bits(acp_pkg::acp_xfer_t)),
      .DEPTH (acp_pkg::FIFO_DEPTH)
   ) u_fifo (
      .mclk      (mclk),
      .rst_b     (rst_b),
      .in_valid  (f_in_valid),
      .in_ready  (f_in_ready),
      .in_data   (in_x),
      .out_valid (f_out_valid),
      .out_ready (f_out_ready),
      .out_data  (out_x)
   );

   ////////////////////////////////////////////////////////////////
   // stack engine
   acp_pkg::acp_state_t state_q;
   logic [7:0]          stk_q [acp_pkg::STACK_DEPTH];
   logic [acp_pkg::SP_W-1:0] sp_q;
   logic [7:0]          cmd_q;
   logic [7:0]          status_q;
   logic [3:0]          exec_q;
   logic [7:0]          rdata_q;
   logic                ovf_q;

   wire idle      = (state_q == acp_pkg::ACP_IDLE);
   assign f_out_ready = idle;
   wire take      = f_out_valid && idle;
   wire do_push   = take && !out_x.cmd_sel && out_x.is_write;
   wire do_pop    = take && !out_x.cmd_sel && !out_x.is_write;
   wire do_cmd    = take && out_x.cmd_sel && out_x.is_write;
   // top of stack is last pushed, so msb pops first
   wire [acp_pkg::SP_W-1:0] top = sp_q - acp_pkg::SP_ONE;
   wire [acp_pkg::SP_W-1:0] nxt = top - acp_pkg::SP_ONE;
   wire [6:0] op  = cmd_q[6:0];
   wire exec_end  = (state_q == acp_pkg::ACP_EXEC) &&
                    (exec_q == acp_pkg::CNT_ZERO);
   wire [7:0] add_r = stk_q[nxt] + stk_q[top];
   wire [7:0] sub_r = stk_q[nxt] - stk_q[top];
   wire two_op = (op == acp_pkg::OP_ADD) || (op == acp_pkg::OP_SUB);
   wire wr_res = exec_end && two_op;

   always_ff @(posedge mclk) begin
      if (!rst_b) begin
         state_q <= acp_pkg::ACP_IDLE;
         sp_q    <= acp_pkg::SP_RESET;
         status_q <= acp_pkg::STATUS_RESET;
         exec_q  <= acp_pkg::CNT_ZERO;
         ovf_q   <= 1'b0;
      end else begin
         unique case (state_q)
            acp_pkg::ACP_IDLE: begin
               if (do_cmd) begin
                  state_q <= acp_pkg::ACP_EXEC;
                  exec_q  <= acp_pkg::EXEC_CNT_W1;
               end
            end
            acp_pkg::ACP_EXEC: begin
               if (exec_end) state_q <= acp_pkg::ACP_DONE;
               else exec_q <= exec_q - 4'h1;
            end
            acp_pkg::ACP_DONE: state_q <= acp_pkg::ACP_IDLE;
            default: state_q <= acp_pkg::ACP_IDLE;
         endcase
         if (do_push) sp_q <= sp_q + acp_pkg::SP_ONE;
         else if (do_pop) sp_q <= top;
         else if (wr_res) sp_q <= top;
         if ((do_push && sp_q == '1) || lost) ovf_q <= 1'b1;
         else if (do_cmd) ovf_q <= 1'b0;
         status_q[acp_pkg::ST_BUSY_BIT]  <= !idle || do_cmd;
         status_q[acp_pkg::ST_EMPTY_BIT] <= (sp_q == acp_pkg::SP_RESET);
         status_q[acp_pkg::ST_ERR_BIT]   <= ovf_q;
      end
   end

   // command survives reset by intent
   always_ff @(posedge mclk) begin
      if (do_cmd) cmd_q <= out_x.data;
   end

   generate
      for (genvar i = 0; i < acp_pkg::STACK_DEPTH; i++) begin : g_stk
         always_ff @(posedge mclk) begin
            if (do_push && sp_q == acp_pkg::SP_W'(i)) begin
               stk_q[i] <= out_x.data;
            end else if (wr_res && nxt == acp_pkg::SP_W'(i)) begin
               stk_q[i] <= (op == acp_pkg::OP_ADD) ? add_r : sub_r;
            end else if (exec_end && op == acp_pkg::OP_XCH) begin
               if (top == acp_pkg::SP_W'(i)) stk_q[i] <= stk_q[nxt];
               if (nxt == acp_pkg::SP_W'(i)) stk_q[i] <= stk_q[top];
            end
         end
      end
   endgenerate

   ////////////////////////////////////////////////////////////////
   // read data and bus drive
   always_ff @(posedge mclk) begin
      if (!rst_b) begin
         rdata_q <= 8'h00;
         db_oe   <= 1'b0;
         db_out  <= 8'h00;
      end else begin
         if (do_pop) rdata_q <= stk_q[top];
         if (rd_start && cs_q) rdata_q <= status_q;
         db_oe  <= rd_any && !both;
         db_out <= rdata_q;
      end
   end

   ////////////////////////////////////////////////////////////////
   // completion and service request
   wire access = rd_start || wr_end;
   always_ff @(posedge mclk) begin
      if (!rst_b) begin
         done_n          <= 1'b1;
         service_request <= 1'b0;
      end else begin
         // setting at completion wins over any clear
         if (exec_end) done_n <= 1'b0;
         else if (!done_ack_n || access) done_n <= 1'b1;
         if (exec_end) begin
            service_request <= cmd_q[acp_pkg::CMD_SVC_BIT];
         end else if (!service_ack_n) begin
            service_request <= 1'b0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////
   // checks
   AST_RST_STATUS: assert property (@(posedge mclk)
      !rst_b |=> status_q == acp_pkg::STATUS_RESET)
      else $error("status not cleared by reset");
   AST_RST_OUT: assert property (@(posedge mclk)
      !rst_b |=> done_n && !service_request)
      else $error("outputs not idle after reset");
   AST_RST_SP: assert property (@(posedge mclk)
      !rst_b |=> sp_q == acp_pkg::SP_RESET)
      else $error("stack pointer not reset");
   AST_RST_ABORT: assert property (@(posedge mclk)
      !rst_b |=> state_q == acp_pkg::ACP_IDLE)
      else $error("command not aborted by reset");
   AST_DONE: assert property (@(posedge mclk) disable iff (!rst_b)
      do_cmd |=> ##8 !done_n)
      else $error("completion not raised after command");
   AST_DONE_CLR: assert property (
      @(posedge mclk) disable iff (!rst_b)
      (!done_ack_n && !exec_end) |=> done_n)
      else $error("completion not cleared by ack");
   AST_SVC: assert property (@(posedge mclk) disable iff (!rst_b)
      exec_end |=> service_request == cmd_q[acp_pkg::CMD_SVC_BIT])
      else $error("service request mismatch");
   AST_PUSH: assert property (@(posedge mclk) disable iff (!rst_b)
      do_push |=> sp_q == $past(sp_q) + acp_pkg::SP_ONE)
      else $error("push did not advance pointer");
   AST_SYNC: assert property (@(posedge mclk) disable iff (!rst_b)
      $rose(wr_s_q) |-> $past(wr_meta_q[0], 2))
      else $error("write strobe bypassed synchroniser");
   AST_DECODE: assert property (@(posedge mclk) disable iff (!rst_b)
      do_cmd |=> cmd_q == $past(out_x.data) && state_q == acp_pkg::ACP_EXEC)
      else $error("command decode wrong");
endmodule
`default_nettype wire

/* verif/acp_host_model.sv */
// host-side partner: byte writes and reads on the strobed bus
`timescale 1ns/1ns
`default_nettype none
module acp_host_model (
   input  wire logic       mclk,
   output var logic        cmd_sel,
   output var logic        rd_n,
   output var logic        wr_n,
   output var logic [7:0]  db_in,
   input  wire logic [7:0] db_out,
   input  wire logic       db_oe
);
   int unsigned slow = 0;

   initial begin
      cmd_sel = 1'b0;
      rd_n = 1'b1;
      wr_n = 1'b1;
      db_in = 8'h00;
   end

   task automatic gap(input int unsigned n);
      repeat (n + slow) @(posedge mclk);
   endtask

   ////////////////////////////////////////////////////////////////////////
   // only one strobe low at a time, so the undefined pair never shows
   task automatic wr(input logic sel, input logic [7:0] d);
      @(posedge mclk);
      cmd_sel <= sel;
      db_in <= d;
      wr_n <= 1'b0;
      gap(6);
      wr_n <= 1'b1;
      gap(6);
      // released bus must not keep showing the old byte
      db_in <= ~d;
   endtask

   task automatic rd(input logic sel, output logic [7:0] q,
                     output logic ok);
      int unsigned n;
      n = 0;
      @(posedge mclk);
      cmd_sel <= sel;
      rd_n <= 1'b0;
      do begin
         @(posedge mclk);
         #1;
         n++;
      end while (db_oe !== 1'b1 && n < 40);
      // popped byte reaches the bus one cycle after status would
      repeat (2) @(posedge mclk);
      #1;
      ok = db_oe;
      q = db_out;
      gap(1);
      rd_n <= 1'b1;
      gap(6);
   endtask
endmodule
`default_nettype wire

/* verif/acp_host_port_tb_top.sv */
// self-checking bench for the coprocessor host port
`timescale 1ns/1ns
`default_nettype none
module acp_host_port_tb_top;
   logic        mclk = 1'b0;
   logic        rst_b = 1'b0;
   logic        done_ack_n = 1'b1;
   logic        service_ack_n = 1'b1;
   logic        cmd_sel, rd_n, wr_n, db_oe, done_n, service_request, ok;
   logic [7:0]  db_in, db_out, q, a, b, cmd;
   logic [7:0]  stk[$];
   logic [6:0]  ops[4] = '{acp_pkg::OP_NOP, acp_pkg::OP_ADD,
                           acp_pkg::OP_SUB, acp_pkg::OP_XCH};
   int unsigned error_cnt = 0;
   int unsigned checks_done = 0;
   int unsigned seed;

   always #5 mclk = ~mclk;

   acp_host_port i_dut (.mclk(mclk), .rst_b(rst_b), .cmd_sel(cmd_sel),
      .rd_n(rd_n), .wr_n(wr_n), .db_in(db_in), .db_out(db_out),
      .db_oe(db_oe), .done_n(done_n), .done_ack_n(done_ack_n),
      .service_request(service_request), .service_ack_n(service_ack_n));
   acp_host_model i_host (.mclk(mclk), .cmd_sel(cmd_sel), .rd_n(rd_n),
      .wr_n(wr_n), .db_in(db_in), .db_out(db_out), .db_oe(db_oe));

   ////////////////////////////////////////////////////////////////////////
   task automatic check_byte(input logic [7:0] got, input logic [7:0] exp);
      checks_done++;
      if (got !== exp) begin
         error_cnt++;
         $display("wrong value at %0t ns: got %h exp %h", $time, got, exp);
      end
   endtask

   task automatic check_bit(input logic got, input logic exp);
      check_byte({7'h00, got}, {7'h00, exp});
   endtask

   task automatic give_verdict;
      $display("checks %0d mismatches %0d", checks_done, error_cnt);
      if (error_cnt == 0 && checks_done > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   function automatic logic svc_of(input logic [7:0] c);
      return c[acp_pkg::CMD_SVC_BIT];
   endfunction

   // idle engine: busy clear, only empty and error can show
   function automatic logic [7:0] status_exp(input logic empty,
                                             input logic err);
      logic [7:0] s;
      s = acp_pkg::STATUS_RESET;
      s[acp_pkg::ST_EMPTY_BIT] = empty;
      s[acp_pkg::ST_ERR_BIT] = err;
      return s;
   endfunction

   // second entry from the top is the left operand
   function automatic logic [7:0] res_exp(input logic [6:0] op,
                                          input logic [7:0] lo,
                                          input logic [7:0] hi);
      return (op == acp_pkg::OP_ADD) ? 8'(lo + hi) : 8'(lo - hi);
   endfunction

   task automatic push(input logic [7:0] d);
      i_host.wr(1'b0, d);
      stk.push_back(d);
   endtask

   task automatic pop_chk;
      i_host.rd(1'b0, q, ok);
      check_bit(ok, 1'b1);
      check_byte(q, stk.pop_back());
   endtask

   task automatic status_chk(input logic [7:0] mask, input logic [7:0] exp);
      i_host.rd(1'b1, q, ok);
      check_byte(q & mask, exp);
   endtask

   task automatic do_reset;
      @(posedge mclk);
      rst_b <= 1'b0;
      repeat (5) @(posedge mclk);
      rst_b <= 1'b1;
      @(posedge mclk);
      #1;
      stk.delete();
      check_bit(done_n, 1'b1);
      check_bit(service_request, 1'b0);
   endtask

   task automatic wait_done;
      int unsigned n;
      n = 0;
      while (done_n !== 1'b0 && n < 100) begin
         @(posedge mclk);
         #1;
         n++;
      end
      check_bit(done_n, 1'b0);
   endtask

   ////////////////////////////////////////////////////////////////////////
   initial begin
      seed = $urandom(38);
      do_reset();
      check_bit(db_oe, 1'b0);
      status_chk(8'hFF, status_exp(1'b1, 1'b0));
      $display("test reset_state done");
      for (int f = 0; f < 6; f++) begin
         i_host.slow = (f % 3) * 2;
         repeat ((f % 2) ? 4 : 2) push(8'($urandom));
         repeat ((f % 2) ? 4 : 2) pop_chk;
      end
      i_host.slow = 0;
      $display("test push_pop done");
      for (int k = 0; k < 8; k++) begin
         cmd = {k[0], ops[k / 2]};
         a = 8'($urandom);
         b = 8'($urandom);
         push(a);
         push(b);
         i_host.wr(1'b1, cmd);
         wait_done;
         check_bit(service_request, svc_of(cmd));
         if (k[1]) begin
            @(posedge mclk);
            done_ack_n <= 1'b0;
            service_ack_n <= 1'b0;
            repeat (3) @(posedge mclk);
            done_ack_n <= 1'b1;
            service_ack_n <= 1'b1;
            repeat (3) @(posedge mclk);
            #1;
            check_bit(done_n, 1'b1);
            check_bit(service_request, 1'b0);
         end
         if (ops[k / 2] inside {acp_pkg::OP_ADD, acp_pkg::OP_SUB}) begin
            void'(stk.pop_back());
            void'(stk.pop_back());
            stk.push_back(res_exp(ops[k / 2], a, b));
            if (k[0]) begin
               do_reset();
               status_chk(8'hFF, status_exp(1'b1, 1'b0));
            end else begin
               pop_chk;
            end
         end else begin
            if (ops[k / 2] == acp_pkg::OP_XCH) begin
               stk[$] = a;
               stk[$ - 1] = b;
            end
            pop_chk;
            check_bit(done_n, 1'b1);
            pop_chk;
         end
      end
      $display("test commands done");
      repeat (17) push(8'($urandom));
      status_chk(8'h01, 8'h01);
      i_host.wr(1'b1, {1'b1, acp_pkg::OP_ADD});
      do_reset();
      for (int n = 0; n < 20; n++) begin
         @(posedge mclk);
         #1;
         check_bit(done_n, 1'b1);
      end
      status_chk(8'hFF, status_exp(1'b1, 1'b0));
      push(8'h5A);
      push(8'hC3);
      pop_chk;
      pop_chk;
      $display("test reset_abort done");
      give_verdict();
   end

   // whole run needs well under 30000 cycles
   initial begin
      #(400000);
      error_cnt++;
      $display("timeout at %0t ns", $time);
      give_verdict();
   end
endmodule
`default_nettype wire
